//--- hw/tcm_map.svh
// Register offsets, field positions, reset values and response codes for the timer channel 2/3 block.
// Summary of operation
// - With shadow enabled, compare writes wait in a shadow until an update event.
// - Fast enable in PWM makes a trigger edge force the compare level.
// - Mode 00 output, 01 own filtered input, 10 other input, 11 trigger.
// - The mode field is writable only while the channel enable is clear.
// - The filter counts equal samples and accepts a level at the threshold.
// - Filter 0 is off; settings 1 to 3 need 2, 4, 8 samples at kernel rate.
// - Settings 4 to 9 sample at dts/2, /4, /8 needing 6 then 8 samples.
// - Settings 10 to 15 need 5, 6, 8 samples at dts/16 and dts/32.
// - Clearing the channel enable clears that prescaler's edge count.
// - Channel 3 has the same filter, prescaler and mode at bits 15:8.
// - The channel 2 compare shadow enable sits at bit 3.
// - Compare mode 110 drives high while the counter is below the compare value.
`ifndef TCM_MAP_SVH
`define TCM_MAP_SVH

`define TCM_OFS_MODE_CTL 8'h00
`define TCM_OFS_CHAN_CTL 8'h04
`define TCM_OFS_CMP_VAL 8'h08
`define TCM_OFS_STATUS 8'h0C

`define TCM_MODE_CTL_RST 16'h0000
`define TCM_CHAN_CTL_RST 8'h00
`define TCM_CMP_VAL_RST 16'h0000

`define TCM_CH2_MS_LSB 0
`define TCM_CH2_FAST_BIT 2
`define TCM_CH2_SHADOW_BIT 3
`define TCM_CH2_CMP_LSB 4
`define TCM_CH2_PSC_LSB 2
`define TCM_CH2_FLT_LSB 4
`define TCM_CH3_MS_LSB 8
`define TCM_CH3_PSC_LSB 10
`define TCM_CH3_FLT_LSB 12

`define TCM_CH2_EN_BIT 0
`define TCM_CH3_EN_BIT 1
`define TCM_SPM_BIT 2
`define TCM_DTS_DIV_LSB 4

`define TCM_RESP_OKAY 2'h0
`define TCM_RESP_SLVERR 2'h2

`endif

//--- hw/tcm_pkg.sv
// Types shared by the timer channel 2/3 mode block.
`default_nettype none
package tcm_pkg;
   typedef enum logic [1:0] {
      TCM_IO_OUTPUT = 2'b00,
      TCM_IO_OWN = 2'b01,
      TCM_IO_CROSS = 2'b10,
      TCM_IO_TRIG = 2'b11
   } tcm_io_mode_t;

   typedef enum logic [2:0] {
      TCM_CMP_TIMING = 3'b000,
      TCM_CMP_SET = 3'b001,
      TCM_CMP_CLEAR = 3'b010,
      TCM_CMP_TOGGLE = 3'b011,
      TCM_CMP_LOW = 3'b100,
      TCM_CMP_HIGH = 3'b101,
      TCM_CMP_PWM0 = 3'b110,
      TCM_CMP_PWM1 = 3'b111
   } tcm_cmp_mode_t;
endpackage
`default_nettype wire

//--- hw/tcm_channel_mode.sv
// Timer channel 2/3 mode control: AXI4-Lite registers, input filters, prescalers, output stage.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`include "tcm_map.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////////////////////////////
module tcm_input_filter (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Configuration and sample strobes
   input wire logic [3:0] cfg,
   input wire logic [5:0] dts_tick,
   // Synchronised input and result
   input wire logic pin_sync,
   output logic level_q
);
   logic sample_en;
   logic [3:0] need;
   logic last_q;
   logic [3:0] run_q;

   always_comb
   begin
      unique case (cfg)
         4'h4, 4'h5: sample_en = dts_tick[1];
         4'h6, 4'h7: sample_en = dts_tick[2];
         4'h8, 4'h9: sample_en = dts_tick[3];
         4'hA, 4'hB, 4'hC: sample_en = dts_tick[4];
         4'hD, 4'hE, 4'hF: sample_en = dts_tick[5];
         default: sample_en = 1'b1;
      endcase
      unique case (cfg)
         4'h0: need = 4'h1;
         4'h1: need = 4'h2;
         4'h2: need = 4'h4;
         4'h4, 4'h6, 4'h8, 4'hB, 4'hE: need = 4'h6;
         4'hA, 4'hD: need = 4'h5;
         default: need = 4'h8;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         last_q <= 1'b0;
         run_q <= 4'h0;
         level_q <= 1'b0;
      end
      else if (cfg == 4'h0)
      begin
         last_q <= pin_sync;
         run_q <= 4'h0;
         level_q <= pin_sync;
      end
      else if (sample_en)
      begin
         last_q <= pin_sync;
         if (pin_sync != last_q)
            run_q <= 4'h1;
         else if (run_q != 4'hF)
            run_q <= run_q + 4'h1;
         if (pin_sync == last_q && run_q + 4'h1 >= need)
            level_q <= pin_sync;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////////////////////
module tcm_capture_psc (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic enable,
   input wire logic [1:0] mode,
   input wire logic [1:0] psc,
   // Selected sources and capture strobe
   input wire logic own_level,
   input wire logic cross_level,
   input wire logic trig_level,
   output logic capture_q
);
   logic sel;
   logic prev_q;
   logic [2:0] edges_q;
   logic [2:0] limit;

   always_comb
   begin
      unique case (tcm_pkg::tcm_io_mode_t'(mode))
         tcm_pkg::TCM_IO_OWN: sel = own_level;
         tcm_pkg::TCM_IO_CROSS: sel = cross_level;
         tcm_pkg::TCM_IO_TRIG: sel = trig_level;
         tcm_pkg::TCM_IO_OUTPUT: sel = 1'b0;
      endcase
   end

   assign limit = (3'h1 << psc) - 3'h1;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_q <= 1'b0;
         edges_q <= 3'h0;
         capture_q <= 1'b0;
      end
      else
      begin
         prev_q <= sel;
         capture_q <= 1'b0;
         if (!enable || mode == 2'b00)
            edges_q <= 3'h0;
         else if (sel && !prev_q)
         begin
            if (edges_q >= limit)
            begin
               edges_q <= 3'h0;
               capture_q <= 1'b1;
            end
            else
               edges_q <= edges_q + 3'h1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////////////////////
module tcm_channel_mode (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer core
   input wire logic [15:0] counter_value,
   input wire logic update_event,
   input wire logic internal_trigger_sig,
   // Capture pins
   input wire logic ch2_in_pin,
   input wire logic ch3_in_pin,
   // Channel results
   output logic ch2_output_pin,
   output logic ch2_capture_evt,
   output logic ch3_capture_evt
);
   logic [15:0] mode_ctl_q;
   logic [7:0] chan_ctl_q;
   logic [15:0] cmp_shadow_q;
   logic [15:0] cmp_active_q;
   logic aw_held_q;
   logic w_held_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_go;
   logic [31:0] wr_mask;
   logic [1:0] sync2_q;
   logic [1:0] sync3_q;
   logic [1:0] dts_cnt_q;
   logic dts_en;
   logic [4:0] div_q;
   logic [5:0] dts_tick;
   logic flt2;
   logic flt3;
   logic cap2;
   logic cap3;
   logic trig_prev_q;
   logic trig_rise;
   logic fast_hold_q;
   logic below;
   logic [7:0] cap2_cnt_q;
   logic [7:0] cap3_cnt_q;
   logic ch2_en;
   logic ch3_en;
   tcm_pkg::tcm_cmp_mode_t cmp_mode;

   assign ch2_en = chan_ctl_q[`TCM_CH2_EN_BIT];
   assign ch3_en = chan_ctl_q[`TCM_CH3_EN_BIT];
   // output-layout view of the shared bits
   assign cmp_mode = tcm_pkg::tcm_cmp_mode_t'(mode_ctl_q[`TCM_CH2_CMP_LSB +: 3]);

   /////////////////////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data are taken in either order, one write in flight.
   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TCM_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q[7:4] == 4'h0)
               s_axi_bresp <= `TCM_RESP_OKAY;
            else
               s_axi_bresp <= `TCM_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Mode fields; each mode field is locked while its channel is enabled.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_ctl_q <= `TCM_MODE_CTL_RST;
      else if (wr_go && aw_addr_q[7:2] == `TCM_OFS_MODE_CTL >> 2)
      begin
         mode_ctl_q <= (mode_ctl_q & ~wr_mask[15:0]) | (w_data_q[15:0] & wr_mask[15:0]);
         if (ch2_en)
            mode_ctl_q[`TCM_CH2_MS_LSB +: 2] <= mode_ctl_q[`TCM_CH2_MS_LSB +: 2];
         if (ch3_en)
            mode_ctl_q[`TCM_CH3_MS_LSB +: 2] <= mode_ctl_q[`TCM_CH3_MS_LSB +: 2];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         chan_ctl_q <= `TCM_CHAN_CTL_RST;
      else if (wr_go && aw_addr_q[7:2] == `TCM_OFS_CHAN_CTL >> 2 && w_strb_q[0])
         chan_ctl_q <= w_data_q[7:0] & 8'h37;
   end

   // Compare value: the shadow always takes the write; the active copy follows at once
   // only when shadowing is off, so PWM without it may glitch mid-period.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmp_shadow_q <= `TCM_CMP_VAL_RST;
         cmp_active_q <= `TCM_CMP_VAL_RST;
      end
      else
      begin
         if (wr_go && aw_addr_q[7:2] == `TCM_OFS_CMP_VAL >> 2)
         begin
            cmp_shadow_q <= (cmp_shadow_q & ~wr_mask[15:0]) | (w_data_q[15:0] & wr_mask[15:0]);
            if (!mode_ctl_q[`TCM_CH2_SHADOW_BIT])
               cmp_active_q <= (cmp_shadow_q & ~wr_mask[15:0]) | (w_data_q[15:0] & wr_mask[15:0]);
         end
         if (update_event && mode_ctl_q[`TCM_CH2_SHADOW_BIT])
            cmp_active_q <= cmp_shadow_q;
      end
   end

   /////////////////////////////////////////////////////////////////////////////////////////////
   // Read channel: answer one cycle after the address is taken.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TCM_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `TCM_RESP_OKAY;
            unique case (s_axi_araddr[7:2])
               `TCM_OFS_MODE_CTL >> 2: s_axi_rdata <= {16'h0000, mode_ctl_q};
               `TCM_OFS_CHAN_CTL >> 2: s_axi_rdata <= {24'h000000, chan_ctl_q};
               `TCM_OFS_CMP_VAL >> 2: s_axi_rdata <= {cmp_active_q, cmp_shadow_q};
               `TCM_OFS_STATUS >> 2:
                  s_axi_rdata <= {cap3_cnt_q, cap2_cnt_q, 13'h0000, ch2_output_pin, flt3, flt2};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `TCM_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   /////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and the dead-time sample clock dividers.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync2_q <= 2'b00;
         sync3_q <= 2'b00;
         dts_cnt_q <= 2'b00;
         div_q <= 5'h00;
      end
      else
      begin
         sync2_q <= {sync2_q[0], ch2_in_pin};
         sync3_q <= {sync3_q[0], ch3_in_pin};
         dts_cnt_q <= dts_en ? 2'b00 : dts_cnt_q + 2'b01;
         if (dts_en)
            div_q <= div_q + 5'h01;
      end
   end

   // Dead-time clock is the kernel clock divided by 1, 2 or 4.
   assign dts_en = (dts_cnt_q >= ((2'b01 << chan_ctl_q[`TCM_DTS_DIV_LSB +: 2]) - 2'b01))
                   || chan_ctl_q[`TCM_DTS_DIV_LSB +: 2] == 2'b00;
   assign dts_tick[0] = dts_en;
   assign dts_tick[1] = dts_en && div_q[0] == 1'b1;
   assign dts_tick[2] = dts_en && div_q[1:0] == 2'b11;
   assign dts_tick[3] = dts_en && div_q[2:0] == 3'b111;
   assign dts_tick[4] = dts_en && div_q[3:0] == 4'hF;
   assign dts_tick[5] = dts_en && div_q == 5'h1F;

   tcm_input_filter u_flt2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(mode_ctl_q[`TCM_CH2_FLT_LSB +: 4]),
      .dts_tick(dts_tick),
      .pin_sync(sync2_q[1]),
      .level_q(flt2)
   );

   tcm_input_filter u_flt3 (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(mode_ctl_q[`TCM_CH3_FLT_LSB +: 4]),
      .dts_tick(dts_tick),
      .pin_sync(sync3_q[1]),
      .level_q(flt3)
   );

   tcm_capture_psc u_psc2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(ch2_en),
      .mode(mode_ctl_q[`TCM_CH2_MS_LSB +: 2]),
      .psc(mode_ctl_q[`TCM_CH2_PSC_LSB +: 2]),
      .own_level(flt2),
      .cross_level(flt3),
      .trig_level(internal_trigger_sig),
      .capture_q(cap2)
   );

   tcm_capture_psc u_psc3 (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(ch3_en),
      .mode(mode_ctl_q[`TCM_CH3_MS_LSB +: 2]),
      .psc(mode_ctl_q[`TCM_CH3_PSC_LSB +: 2]),
      .own_level(flt3),
      .cross_level(flt2),
      .trig_level(internal_trigger_sig),
      .capture_q(cap3)
   );

   assign ch2_capture_evt = cap2;
   assign ch3_capture_evt = cap3;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cap2_cnt_q <= 8'h00;
         cap3_cnt_q <= 8'h00;
      end
      else
      begin
         cap2_cnt_q <= cap2_cnt_q + {7'h00, cap2};
         cap3_cnt_q <= cap3_cnt_q + {7'h00, cap3};
      end
   end

   /////////////////////////////////////////////////////////////////////////////////////////////
   // Output compare stage for channel 2.
   assign below = counter_value < cmp_active_q;
   assign trig_rise = internal_trigger_sig && !trig_prev_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trig_prev_q <= 1'b0;
         fast_hold_q <= 1'b0;
         ch2_output_pin <= 1'b0;
      end
      else
      begin
         trig_prev_q <= internal_trigger_sig;
         if (trig_rise && mode_ctl_q[`TCM_CH2_FAST_BIT]
             && (cmp_mode == tcm_pkg::TCM_CMP_PWM0 || cmp_mode == tcm_pkg::TCM_CMP_PWM1))
            fast_hold_q <= 1'b1;
         else if (update_event)
            fast_hold_q <= 1'b0;
         if (mode_ctl_q[`TCM_CH2_MS_LSB +: 2] == 2'b00)
         begin
            unique case (cmp_mode)
               tcm_pkg::TCM_CMP_TIMING: ch2_output_pin <= ch2_output_pin;
               tcm_pkg::TCM_CMP_SET: if (counter_value == cmp_active_q) ch2_output_pin <= 1'b1;
               tcm_pkg::TCM_CMP_CLEAR: if (counter_value == cmp_active_q) ch2_output_pin <= 1'b0;
               tcm_pkg::TCM_CMP_TOGGLE:
                  if (counter_value == cmp_active_q)
                     ch2_output_pin <= !ch2_output_pin;
               tcm_pkg::TCM_CMP_LOW: ch2_output_pin <= 1'b0;
               tcm_pkg::TCM_CMP_HIGH: ch2_output_pin <= 1'b1;
               tcm_pkg::TCM_CMP_PWM0: ch2_output_pin <= below && !fast_hold_q && !trig_rise;
               tcm_pkg::TCM_CMP_PWM1: ch2_output_pin <= !below || fast_hold_q || trig_rise;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- verif/tcm_channel_mode_checker.sv
// Concurrent checks on the ports of the timer channel 2/3 mode block.
`default_nettype none
module tcm_channel_mode_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Channel results
   input wire logic ch2_output_pin,
   input wire logic ch2_capture_evt,
   input wire logic ch3_capture_evt
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   property p_aw_pulse;
      s_axi_awready |=> !s_axi_awready;
   endproperty
   a_aw_pulse: assert property (p_aw_pulse) else $error("awready held too long");
   property p_b_after;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_after: assert property (p_b_after) else $error("write response missing");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_b_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("write response repeated");
   property p_r_after;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_after: assert property (p_r_after) else $error("read data late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data unstable");
   // Two qualified edges need at least two samples, so captures never abut.
   property p_cap2;
      ch2_capture_evt |=> !ch2_capture_evt;
   endproperty
   a_cap2: assert property (p_cap2) else $error("ch2 capture too long");
   property p_cap3;
      ch3_capture_evt |=> !ch3_capture_evt;
   endproperty
   a_cap3: assert property (p_cap3) else $error("ch3 capture too long");
   property p_rst;
      disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !ch2_output_pin
         && !ch2_capture_evt && !ch3_capture_evt;
   endproperty
   a_rst: assert property (p_rst) else $error("output active in reset");
   c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   c_cap2: cover property (ch2_capture_evt);
   c_cap3: cover property (ch3_capture_evt);
   c_out: cover property ($rose(ch2_output_pin));
endmodule
`default_nettype wire

//--- verif/tcm_pin_model.sv
// Model of the capture pins and the internal trigger facing the channel block.
`default_nettype none
module tcm_pin_model (
   // Clock
   input wire logic aclk,
   // Driven lines
   output var logic ch2_pin,
   output var logic ch3_pin,
   output var logic trig
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      ch2_pin = 1'b0;
      ch3_pin = 1'b0;
      trig = 1'b0;
   end
   // Holds a level for n cycles; sel 0 is ch2, 1 is ch3, else the trigger.
   task automatic drive(input int sel, input logic lvl, input int n);
      @(posedge aclk);
      case (sel)
         0: ch2_pin <= lvl;
         1: ch3_pin <= lvl;
         default: trig <= lvl;
      endcase
      repeat (n - 1) @(posedge aclk);
   endtask
   task automatic pulses(input int sel, input int hi, input int lo, input int k);
      repeat (k)
      begin
         drive(sel, 1'b1, hi);
         drive(sel, 1'b0, lo);
      end
   endtask
endmodule
`default_nettype wire

//--- verif/tcm_channel_mode_tb.sv
// Self-checking testbench for the timer channel 2/3 mode block.
`include "tcm_map.svh"
`default_nettype none
module tcm_channel_mode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_MODE = `TCM_OFS_MODE_CTL;
   localparam logic [7:0] A_CHAN = `TCM_OFS_CHAN_CTL;
   localparam logic [7:0] A_CMP = `TCM_OFS_CMP_VAL;
   localparam logic [1:0] OK = `TCM_RESP_OKAY;
   localparam logic [1:0] ERR = `TCM_RESP_SLVERR;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, update_event, ch2_pin, ch3_pin, trig;
   logic out2, cap2_evt, cap3_evt;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic [15:0] counter_value;
   int miscompares, checked, cyc, cap2, cap3;
   int ft[6] = '{1, 3, 4, 9, 10, 15};
   int sh[6] = '{1, 5, 8, 40, 48, 160};
   int lg[6] = '{4, 10, 14, 72, 96, 300};
   tcm_channel_mode dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .counter_value(counter_value), .update_event(update_event),
      .internal_trigger_sig(trig), .ch2_in_pin(ch2_pin), .ch3_in_pin(ch3_pin),
      .ch2_output_pin(out2), .ch2_capture_evt(cap2_evt), .ch3_capture_evt(cap3_evt));
   tcm_pin_model pins_u (.aclk(aclk), .ch2_pin(ch2_pin), .ch3_pin(ch3_pin), .trig(trig));
   ////////////////////////////////////////
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cap2_evt === 1'b1) cap2 <= cap2 + 1;
      if (cap3_evt === 1'b1) cap3 <= cap3 + 1;
      if (cyc == 60000)
      begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t output %b expected %b", $time, got, exp);
      end
   endtask
   task automatic cmp_count(input int got, input int exp);
      checked++;
      if (got != exp)
      begin
         miscompares++;
         $display("BAD %0t captures %0d expected %0d", $time, got, exp);
      end
   endtask
   // Ready is raised late on purpose so that the slave must hold its answer.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      repeat (2) @(posedge aclk);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      cmp_word({30'h0, bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (arvalid);
      repeat (2) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      cmp_word(rdata, ed);
      cmp_word({30'h0, rresp}, {30'h0, er});
   endtask
   task automatic upd();
      @(posedge aclk);
      update_event <= 1'b1;
      @(posedge aclk);
      update_event <= 1'b0;
   endtask
   task automatic out_is(input logic [15:0] c, input logic e);
      @(posedge aclk);
      counter_value <= c;
      repeat (4) @(posedge aclk);
      cmp_bit(out2, e);
   endtask
   task automatic cap_case(input logic [31:0] m, input logic [31:0] c, input int sel,
      input int hi, input int lo, input int k, input int e2, input int e3);
      wr(A_CHAN, 32'h0, OK);
      wr(A_MODE, m, OK);
      wr(A_CHAN, c, OK);
      cap2 = 0;
      cap3 = 0;
      pins_u.pulses(sel, hi, lo, k);
      repeat (8) @(posedge aclk);
      cmp_count(cap2, e2);
      cmp_count(cap3, e3);
   endtask
   ////////////////////////////////////////
   initial
   begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      counter_value = 16'h0000;
      update_event = 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(A_MODE, 32'h0, OK);
      rd(A_CHAN, 32'h0, OK);
      rd(A_CMP, 32'h0, OK);
      rd(8'h10, 32'h0, ERR);
      wr(8'h10, 32'hFFFF_FFFF, ERR);
      wr(A_MODE, 32'h0101, OK);
      wr(A_CHAN, 32'h0003, OK);
      wr(A_MODE, 32'h0202, OK);
      rd(A_MODE, 32'h0101, OK);
      wr(A_CHAN, 32'h0000, OK);
      wr(A_MODE, 32'h0068, OK);
      wr(A_CMP, 32'h0010, OK);
      rd(A_CMP, 32'h0000_0010, OK);
      upd();
      rd(A_CMP, 32'h0010_0010, OK);
      out_is(16'h000F, 1'b1);
      out_is(16'h0010, 1'b0);
      wr(A_CHAN, 32'h0004, OK);
      wr(A_MODE, 32'h0064, OK);
      wr(A_CMP, 32'h0020, OK);
      rd(A_CMP, 32'h0020_0020, OK);
      out_is(16'h0000, 1'b1);
      pins_u.pulses(2, 2, 2, 1);
      out_is(16'h0000, 1'b0);
      upd();
      out_is(16'h0000, 1'b1);
      wr(A_MODE, 32'h0074, OK);
      out_is(16'h0000, 1'b0);
      pins_u.pulses(2, 2, 2, 1);
      out_is(16'h0000, 1'b1);
      for (int p = 0; p < 4; p++)
         cap_case(32'h1 | (p << 2), 32'h1, 0, 4, 4, 8, 8 >> p, 0);
      cap_case(32'h0002, 32'h1, 1, 4, 4, 3, 3, 0);
      // The block has no trigger select, so the trigger line is taken as chosen.
      cap_case(32'h0003, 32'h1, 2, 4, 4, 3, 3, 0);
      cap_case(32'h0500, 32'h2, 1, 4, 4, 4, 0, 2);
      cap_case(32'h0600, 32'h2, 0, 4, 4, 4, 0, 2);
      cap_case(32'h0001, 32'h1, 0, 1, 4, 2, 2, 0);
      cap_case(32'h000D, 32'h1, 0, 4, 4, 4, 0, 0);
      wr(A_CHAN, 32'h0, OK);
      wr(A_CHAN, 32'h1, OK);
      pins_u.pulses(0, 4, 4, 4);
      repeat (8) @(posedge aclk);
      cmp_count(cap2, 0);
      for (int i = 0; i < 6; i++)
      begin
         cap_case(32'h1 | (ft[i] << 4), 32'h1, 0, sh[i], lg[i], 1, 0, 0);
         cap_case(32'h1 | (ft[i] << 4), 32'h1, 0, lg[i], lg[i], 1, 1, 0);
      end
      cap_case(32'h0031, 32'h1, 0, 5, 1, 2, 0, 0);
      rd(`TCM_OFS_STATUS, 32'h041D_0004, OK);
      end_of_test();
   end
endmodule
bind tcm_channel_mode tcm_channel_mode_checker chk_u (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .ch2_output_pin(ch2_output_pin), .ch2_capture_evt(ch2_capture_evt),
   .ch3_capture_evt(ch3_capture_evt));
`default_nettype wire
